// ### core/dsi_params.svh
`ifndef DSI_PARAMS_SVH
`define DSI_PARAMS_SVH

// Logic clock rate
`define DSI_CLK_MHZ 25
// Interface pulse length in ns
`define DSI_PULSE_NS 1000
// Interface pulse length in clock cycles, rounded up
`define DSI_PULSE_CYC ((`DSI_PULSE_NS * `DSI_CLK_MHZ + 999) / 1000)
// Platter indices
`define DSI_UPPER 0
`define DSI_LOWER 1
// Default widths and counts
`define DSI_SEC_W 8
`define DSI_GATE_W 8
`define DSI_DIV_W 16
`define DSI_PULSE_W 8
// Reset value and synchroniser depth
`define DSI_CNT_RST 0
`define DSI_SYNC_DEPTH 2

`endif

// ### core/dsi_pkg.sv
package dsi_pkg;

    // Jumper style configuration of the sectoring arrays
    typedef struct packed {
        logic upper_elec_en;
        logic upper_index_only;
        logic vco_div2_sel;
    } dsi_jumpers_t;

    // Demultiplexed pulse pair of one platter
    typedef struct packed {
        logic index;
        logic sector;
    } dsi_pulse_pair_t;

    // Demultiplexer gap timer state
    typedef enum logic [0:0] {
        DM_IDLE,
        DM_TIMING
    } dsi_dm_state_t;

endpackage

// ### core/dsi_pulse_former.sv
`timescale 1ns/1ps
`include "dsi_params.svh"

module dsi_pulse_former #(
    parameter int PULSE_W = `DSI_PULSE_W,
    parameter logic [PULSE_W-1:0] PULSE_CYC = PULSE_W'(`DSI_PULSE_CYC)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic trig,
    output logic pulse
);
    logic [PULSE_W-1:0] left_reg;

    // Stretch one-cycle trigger into fixed length pulse
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            left_reg <= '0;
        end else if (trig) begin
            left_reg <= PULSE_CYC;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - PULSE_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= trig || (left_reg > PULSE_W'(1));
        end
    end

endmodule

// ### core/dsi_gen.sv
`timescale 1ns/1ps
`include "dsi_params.svh"

module dsi_gen #(
    parameter int SEC_W = `DSI_SEC_W,
    parameter int GATE_W = `DSI_GATE_W,
    parameter int DIV_W = `DSI_DIV_W,
    parameter int PULSE_W = `DSI_PULSE_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic upper_sensor_raw,
    input wire logic lower_sensor_raw,
    input wire logic vco_raw,
    input wire logic gate_tick,
    input wire logic motor_run_enable,
    input wire logic upper_platter_sel,
    input wire logic upper_platter_sel_n,
    input wire logic selected_and_ready_n,
    input wire dsi_pkg::dsi_jumpers_t jumpers,
    input wire logic [GATE_W-1:0] upper_gate_time,
    input wire logic [GATE_W-1:0] lower_gate_time,
    input wire logic [DIV_W-1:0] pll_terminal_count,
    input wire logic [DIV_W-1:0] upper_sector_div,
    input wire logic [DIV_W-1:0] lower_sector_div,
    output logic iface_sector_pulse,
    output logic iface_index_pulse,
    output logic [SEC_W-1:0] iface_sector_count,
    output logic lower_high_sensitivity,
    output logic phase_ref_sq,
    output logic pll_div_sq,
    output logic phase_error
);
    import dsi_pkg::*;

    // Synchronisers and edge detectors for raw inputs
    logic [2:0] raw_in;
    logic [2:0] raw_rise;
    assign raw_in = {vco_raw, lower_sensor_raw, upper_sensor_raw};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic meta_reg;
            logic stable_reg;
            logic last_reg;
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                    last_reg <= 1'b0;
                end else begin
                    meta_reg <= raw_in[gi];
                    stable_reg <= meta_reg;
                    last_reg <= stable_reg;
                end
            end
            assign raw_rise[gi] = stable_reg && !last_reg;
        end
    endgenerate

    // Gate time demultiplexers, upper and lower
    logic [GATE_W-1:0] gate_time [2];
    dsi_pulse_pair_t demux [2];
    assign gate_time[`DSI_UPPER] = upper_gate_time;
    assign gate_time[`DSI_LOWER] = lower_gate_time;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_demux
            dsi_dm_state_t state_reg;
            logic [GATE_W-1:0] gap_reg;
            logic close_gap;
            assign close_gap = (state_reg == DM_TIMING) && (gap_reg < gate_time[gi]);

            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    state_reg <= DM_IDLE;
                end else begin
                    case (state_reg)
                        DM_IDLE: begin
                            if (raw_rise[gi]) begin
                                state_reg <= DM_TIMING;
                            end
                        end
                        default: begin
                            state_reg <= DM_TIMING;
                        end
                    endcase
                end
            end

            // Gap since previous pulse, in gate_tick reference ticks
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    gap_reg <= '0;
                end else if (raw_rise[gi]) begin
                    gap_reg <= '0;
                end else if (gate_tick && gap_reg != '1) begin
                    gap_reg <= gap_reg + GATE_W'(1);
                end
            end

            // Short gap marks the interposed index; long gap a sector or lone index
            always_comb begin
                demux[gi].index = raw_rise[gi] && close_gap;
                demux[gi].sector = raw_rise[gi] && !close_gap;
            end
        end
    endgenerate

    // Lower detector threshold control
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lower_high_sensitivity <= 1'b1;
        end else begin
            lower_high_sensitivity <= !motor_run_enable;
        end
    end

    // Phase lock flip-flop from the phase-lock notch line
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_ref_sq <= 1'b0;
        end else if (demux[`DSI_LOWER].sector) begin
            phase_ref_sq <= !phase_ref_sq;
        end
    end

    // Oscillator divider and terminal count
    logic vco_half_reg;
    logic [DIV_W-1:0] pll_cnt_reg;
    logic vco_edge;
    logic pll_terminal;
    assign vco_edge = raw_rise[2];
    assign pll_terminal = vco_edge && (pll_cnt_reg >= pll_terminal_count);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pll_cnt_reg <= '0;
        end else if (pll_terminal) begin
            pll_cnt_reg <= '0;
        end else if (vco_edge) begin
            pll_cnt_reg <= pll_cnt_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pll_div_sq <= 1'b0;
        end else if (pll_terminal) begin
            pll_div_sq <= !pll_div_sq;
        end
    end

    // Digital phase comparison of the two square waves
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_error <= 1'b0;
        end else begin
            phase_error <= pll_div_sq ^ phase_ref_sq;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            vco_half_reg <= 1'b0;
        end else if (vco_edge) begin
            vco_half_reg <= !vco_half_reg;
        end
    end

    // Sectoring clock tick, direct or halved
    logic sect_tick;
    assign sect_tick = vco_edge && (!jumpers.vco_div2_sel || vco_half_reg);

    // Raw index per platter
    logic raw_index [2];
    assign raw_index[`DSI_UPPER] = jumpers.upper_index_only ? demux[`DSI_UPPER].sector
                                                            : demux[`DSI_UPPER].index;
    assign raw_index[`DSI_LOWER] = demux[`DSI_LOWER].index;

    // Electronic sectoring per platter
    logic elec_en [2];
    assign elec_en[`DSI_UPPER] = jumpers.upper_elec_en || jumpers.upper_index_only;
    assign elec_en[`DSI_LOWER] = 1'b1;

    logic [DIV_W-1:0] sector_div [2];
    assign sector_div[`DSI_UPPER] = upper_sector_div;
    assign sector_div[`DSI_LOWER] = lower_sector_div;

    logic raw_sector [2];
    logic [SEC_W-1:0] sec_num [2];
    logic formed_sector [2];
    logic formed_index [2];

    generate
        for (gi = 0; gi < 2; gi++) begin : g_platter
            logic index_sync_reg;
            logic [DIV_W-1:0] cd_reg;
            logic cd_pulse;
            logic [SEC_W-1:0] num_reg;

            // Index synchroniser for the countdown
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    index_sync_reg <= 1'b0;
                end else begin
                    index_sync_reg <= raw_index[gi];
                end
            end

            // Divide sectoring clock; pulse every sector_div ticks
            assign cd_pulse = sect_tick && !index_sync_reg
                && (cd_reg >= sector_div[gi] - DIV_W'(1));

            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    cd_reg <= '0;
                end else if (index_sync_reg) begin
                    cd_reg <= '0;
                end else if (cd_pulse) begin
                    cd_reg <= '0;
                end else if (sect_tick) begin
                    cd_reg <= cd_reg + DIV_W'(1);
                end
            end

            // Source of raw sector pulses
            assign raw_sector[gi] = elec_en[gi] ? cd_pulse
                                                : demux[gi].sector;

            // Sector number counter with count control
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    num_reg <= SEC_W'(`DSI_CNT_RST);
                end else if (raw_index[gi]) begin
                    num_reg <= '0;
                end else if (raw_sector[gi]) begin
                    num_reg <= num_reg + SEC_W'(1);
                end
            end
            assign sec_num[gi] = num_reg;

            dsi_pulse_former #(
                .PULSE_W(PULSE_W)
            ) u_sector_former (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .trig(raw_sector[gi]),
                .pulse(formed_sector[gi])
            );

            dsi_pulse_former #(
                .PULSE_W(PULSE_W)
            ) u_index_former (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .trig(raw_index[gi]),
                .pulse(formed_index[gi])
            );
        end
    endgenerate

    // Mux steering decode for one platter
    function automatic logic platter_on(
        input logic want_upper,
        input logic sel,
        input logic sel_n,
        input logic ready_n
    );
        logic is_upper;
        logic is_lower;
        is_upper = sel && !sel_n;
        is_lower = !sel && sel_n;
        return !ready_n && (want_upper ? is_upper : is_lower);
    endfunction

    // Pulse multiplexer for one interface line
    function automatic logic pulse_mux(
        input logic up_on,
        input logic lo_on,
        input logic up_pulse,
        input logic lo_pulse
    );
        return (up_on && up_pulse) || (lo_on && lo_pulse);
    endfunction

    // Multiplexer control
    logic upper_on;
    logic lower_on;
    assign upper_on = platter_on(1'b1, upper_platter_sel, upper_platter_sel_n,
        selected_and_ready_n);
    assign lower_on = platter_on(1'b0, upper_platter_sel, upper_platter_sel_n,
        selected_and_ready_n);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            iface_sector_pulse <= 1'b0;
        end else begin
            iface_sector_pulse <= pulse_mux(upper_on, lower_on,
                formed_sector[`DSI_UPPER], formed_sector[`DSI_LOWER]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            iface_index_pulse <= 1'b0;
        end else begin
            iface_index_pulse <= pulse_mux(upper_on, lower_on,
                formed_index[`DSI_UPPER], formed_index[`DSI_LOWER]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            iface_sector_count <= '0;
        end else if (upper_on) begin
            iface_sector_count <= sec_num[`DSI_UPPER];
        end else if (lower_on) begin
            iface_sector_count <= sec_num[`DSI_LOWER];
        end else begin
            iface_sector_count <= '0;
        end
    end

endmodule

// ### testbench/dsi_ctrl_model.sv
`timescale 1ns/1ps

// Controller side: drives the platter select lines
module dsi_ctrl_model (
    input wire logic ref_clk,
    input wire logic [1:0] mode,
    output logic upper_platter_sel,
    output logic upper_platter_sel_n,
    output logic selected_and_ready_n
);
    // Mode 1 upper, 2 or 3 lower, 0 nothing ready
    always @(posedge ref_clk) begin
        upper_platter_sel <= (mode == 2'h1);
        upper_platter_sel_n <= (mode != 2'h1);
        selected_and_ready_n <= (mode == 2'h0);
    end
endmodule

// ### testbench/dsi_gen_props.sv
`timescale 1ns/1ps

module dsi_gen_props #(
    parameter int SEC_W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic motor_run_enable,
    input wire logic upper_platter_sel,
    input wire logic upper_platter_sel_n,
    input wire logic selected_and_ready_n,
    input wire logic iface_sector_pulse,
    input wire logic iface_index_pulse,
    input wire logic [SEC_W-1:0] iface_sector_count,
    input wire logic lower_high_sensitivity,
    input wire logic phase_ref_sq,
    input wire logic pll_div_sq,
    input wire logic phase_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [2:0] sel_now;
    logic [2:0] sel_q;
    logic [7:0] st_cnt;
    logic [7:0] sp_len;
    logic [7:0] ip_len;
    logic none_sel;
    logic stab;
    assign sel_now = {upper_platter_sel, upper_platter_sel_n, selected_and_ready_n};
    assign none_sel = selected_and_ready_n || (upper_platter_sel == upper_platter_sel_n);
    assign stab = !none_sel && (st_cnt > 8'h28);
    // Cycles since the select lines last changed
    always_ff @(posedge ref_clk) begin
        sel_q <= sel_now;
        if (!nrst || sel_q != sel_now) st_cnt <= 8'h00;
        else if (st_cnt != 8'hFF) st_cnt <= st_cnt + 8'h01;
    end
    // Length of the current sector pulse
    always_ff @(posedge ref_clk) begin
        if (!iface_sector_pulse) sp_len <= 8'h00;
        else if (sp_len != 8'hFF) sp_len <= sp_len + 8'h01;
    end
    // Length of the current index pulse
    always_ff @(posedge ref_clk) begin
        if (!iface_index_pulse) ip_len <= 8'h00;
        else if (ip_len != 8'hFF) ip_len <= ip_len + 8'h01;
    end
    AST_HISENS: assert property (
        $past(nrst) |-> lower_high_sensitivity == !$past(motor_run_enable))
        else $error("threshold select wrong");
    AST_PHERR: assert property (
        $past(nrst) |-> phase_error == ($past(pll_div_sq) ^ $past(phase_ref_sq)))
        else $error("phase compare wrong");
    AST_NOSEL: assert property (
        none_sel [*3] |-> !iface_sector_pulse && !iface_index_pulse && iface_sector_count == '0)
        else $error("outputs active while not selected");
    AST_SP_LEN: assert property (
        $fell(iface_sector_pulse) && stab |-> sp_len inside {8'h19, 8'h1A})
        else $error("sector pulse length wrong");
    AST_IP_LEN: assert property (
        $fell(iface_index_pulse) && stab |-> ip_len inside {8'h19, 8'h1A})
        else $error("index pulse length wrong");
    AST_CNT_STEP: assert property (
        stab && $changed(iface_sector_count) |->
            iface_sector_count == '0 || iface_sector_count == SEC_W'($past(iface_sector_count) + 1))
        else $error("sector number jumped");
    AST_CNT_PULSE: assert property (
        stab && $changed(iface_sector_count) && iface_sector_count != '0 |-> ##[0:1] iface_sector_pulse)
        else $error("count advanced without sector pulse");
    AST_IDX_CLR: assert property (
        stab && $rose(iface_index_pulse) |-> ##[0:1] iface_sector_count == '0)
        else $error("index did not clear count");
    COV_IDX: cover property (stab && $rose(iface_index_pulse));
    COV_CNT: cover property (stab && $changed(iface_sector_count));
    COV_PH: cover property ($rose(phase_ref_sq));
endmodule

// ### testbench/disk_sector_index_generator_tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module disk_sector_index_generator_tb_top;
    import dsi_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic upper_sensor_raw = 1'b0;
    logic lower_sensor_raw = 1'b0;
    logic vco_raw = 1'b0;
    logic gate_tick = 1'b0;
    logic motor_run_enable = 1'b0;
    logic vco_run = 1'b0;
    logic vph = 1'b0;
    logic [1:0] mode = 2'h0;
    dsi_jumpers_t jumpers = '0;
    logic upper_platter_sel, upper_platter_sel_n, selected_and_ready_n;
    logic iface_sector_pulse, iface_index_pulse, lower_high_sensitivity;
    logic phase_ref_sq, pll_div_sq, phase_error;
    logic [7:0] iface_sector_count;
    int bad_count = 0;
    int num_checks = 0;
    int ucnt = 0;
    int lastgap = 1000;
    int i, n, p;
    bit ph = 0;

    always #20 ref_clk = ~ref_clk;
    // Tick every other cycle; oscillator at a quarter of the clock
    always @(posedge ref_clk) begin
        #1;
        gate_tick = ~gate_tick;
        vph = ~vph;
        if (vco_run && vph) vco_raw = ~vco_raw;
    end

    dsi_ctrl_model u_ctrl (.ref_clk(ref_clk), .mode(mode), .upper_platter_sel(upper_platter_sel),
        .upper_platter_sel_n(upper_platter_sel_n), .selected_and_ready_n(selected_and_ready_n));

    dsi_gen DUT (.ref_clk(ref_clk), .nrst(nrst), .upper_sensor_raw(upper_sensor_raw),
        .lower_sensor_raw(lower_sensor_raw), .vco_raw(vco_raw), .gate_tick(gate_tick),
        .motor_run_enable(motor_run_enable), .upper_platter_sel(upper_platter_sel),
        .upper_platter_sel_n(upper_platter_sel_n), .selected_and_ready_n(selected_and_ready_n),
        .jumpers(jumpers), .upper_gate_time(8'h14), .lower_gate_time(8'h14),
        .pll_terminal_count(16'h0003), .upper_sector_div(16'h000A),
        .lower_sector_div(16'h001E), .iface_sector_pulse(iface_sector_pulse),
        .iface_index_pulse(iface_index_pulse), .iface_sector_count(iface_sector_count),
        .lower_high_sensitivity(lower_high_sensitivity), .phase_ref_sq(phase_ref_sq),
        .pll_div_sq(pll_div_sq), .phase_error(phase_error));

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One raw pulse, checked, then the gap to the next one (short gap: index)
    task automatic pls(input bit lo, input int gap);
        bit idx;
        idx = lastgap < 40;
        if (lo) lower_sensor_raw = 1'b1;
        else upper_sensor_raw = 1'b1;
        step(2);
        lower_sensor_raw = 1'b0;
        upper_sensor_raw = 1'b0;
        step(5);
        if (lo) begin
            if (!idx) ph = !ph;
            `CHK(phase_ref_sq, ph)
            `CHK(iface_index_pulse, idx)
        end else begin
            ucnt = idx ? 0 : (ucnt + 1) % 256;
            if (mode == 2'h1) begin
                `CHK(iface_sector_count, ucnt[7:0])
                `CHK(iface_index_pulse, idx)
                if (!idx) `CHK(iface_sector_pulse, 1'b1)
            end else begin
                `CHK(({iface_index_pulse, iface_sector_pulse, iface_sector_count}), 10'h000)
            end
        end
        lastgap = gap;
        step(gap - 7);
    endtask

    initial begin
        void'($urandom(32'hB199));
        step(5);
        nrst = 1'b1;
        `CHK(({iface_sector_pulse, iface_index_pulse, iface_sector_count}), 10'h000)
        `CHK(lower_high_sensitivity, 1'b1)
        motor_run_enable = 1'b1;
        step(2);
        `CHK(lower_high_sensitivity, 1'b0)
        for (i = 0; i < 16; i++) begin
            if (i % 4 == 0) mode = ($urandom % 3 != 0) ? 2'h1 : 2'h0;
            pls(1'b0, (i % 4 == 2) ? 8 : 90 + $urandom % 40);
        end
        mode = 2'h2;
        lastgap = 1000;
        for (i = 0; i < 8; i++) pls(1'b1, (i == 5) ? 8 : 90 + $urandom % 40);
        mode = 2'h1;
        vco_run = 1'b1;
        for (n = 0; n < 2; n++) begin
            jumpers = {1'b0, 1'b1, n[0]};
            p = 40 * (n + 1);
            step(200);
            upper_sensor_raw = 1'b1;
            step(2);
            upper_sensor_raw = 1'b0;
            step(5);
            `CHK(iface_index_pulse, 1'b1)
            `CHK(iface_sector_count, 8'h00)
            step(p / 2 - 7);
            for (i = 1; i <= 3; i++) begin
                step(p);
                `CHK(iface_sector_count, i[7:0])
            end
        end
        // Divider square wave: 80 oscillator rises in 320 cycles, 4 rises per half period
        n = 0;
        for (i = 0; i < 320; i++) begin
            p = pll_div_sq;
            step(1);
            if (pll_div_sq !== p[0]) n++;
        end
        `CHK((n >= 19 && n <= 21), 1'b1)
        motor_run_enable = 1'b0;
        step(2);
        `CHK(lower_high_sensitivity, 1'b1)
        results();
    end

    initial begin
        step(20000);
        bad_count++;
        results();
    end
endmodule

bind dsi_gen dsi_gen_props #(.SEC_W(SEC_W)) u_props (.ref_clk, .nrst, .motor_run_enable,
    .upper_platter_sel, .upper_platter_sel_n, .selected_and_ready_n, .iface_sector_pulse,
    .iface_index_pulse, .iface_sector_count, .lower_high_sensitivity, .phase_ref_sq,
    .pll_div_sq, .phase_error);
